/* common/prom_prog_pkg.sv */
// constants, states and carriers for the registered prom fuse programmer
package prom_prog_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int BIT_W = 3;
  localparam int CLK_MHZ = 125;
  localparam int PULSE_US = 10;
  localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
  localparam int SETTLE_US = 5;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int GAP_NS = 104;
  localparam int GAP_CYC = (GAP_NS + 7) / 8;
  localparam int MAX_TRIES = 10;
  localparam int EXTRA_PULSES = 5;
  localparam int DUTY_PCT = 25;
  localparam int DUTY_MULT = 100 / DUTY_PCT - 1;
  localparam int CNT_W = 16;
  localparam int CNT_RST = 0;
  localparam logic [ADDR_W-1:0] INIT_ADDR = 10'h0200;

  typedef enum logic [10:0] {
    ST_IDLE = 11'h001,
    ST_SETUP = 11'h002,
    ST_RAISE = 11'h004,
    ST_PULSE = 11'h008,
    ST_DROP = 11'h010,
    ST_VLOW = 11'h020,
    ST_VHIGH = 11'h040,
    ST_CHECK = 11'h080,
    ST_COOL = 11'h100,
    ST_DONE = 11'h200,
    ST_FAIL = 11'h400
  } prog_state_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic init_n;
    logic oe_n;
    logic reg_clk;
    logic vcc_prog;
    logic vcc_vlow;
    logic vcc_vhigh;
    logic [DATA_W-1:0] out_prog;
  } pin_drive_s;

  typedef struct packed {
    prog_state_e state;
    pin_drive_s pins;
    logic [BIT_W-1:0] bit_sel;
    logic [CNT_W-1:0] timer;
    logic [CNT_W+2:0] cool;
    logic [3:0] tries;
    logic [2:0] extras;
    logic verified;
    logic sample_ok;
    logic busy;
    logic done;
    logic fail;
    logic [DATA_W-1:0] sync_a;
    logic [DATA_W-1:0] sync_b;
  } prog_s;
endpackage

/* rtl/prom_fuse_programmer.sv */
// fuse programming sequencer for one bit of a registered bipolar prom
// Function
// - enable pulse of 10 us with outputs enabled is the programming pulse
// - drop output programming level, then verify at low and high supply
// - a rising register clock edge precedes every verification read
// - keep device enabled while verification reads are sensed
// - repeat supply, output, pulse sequence up to ten attempts
// - initialize input low selects the initialize word as target
// - initialize input driven from inverted upper address bit, word at 512
// - five extra programming pulses after the bit verifies
// - whole sequence runs separately for every bit to become high
// - supply at programming level at most 25 percent of time
// - read back full memory after programming is recommended
// - programming level on one output only, others left open
// - address present and enable held high before supply rises
`timescale 1ns/10ps
`default_nettype none
module prom_fuse_programmer
  import prom_prog_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [prom_prog_pkg::ADDR_W-1:0] i_addr,
  input wire logic [prom_prog_pkg::BIT_W-1:0] i_bit,
  input wire logic [prom_prog_pkg::DATA_W-1:0] i_prom_q,
  output logic [prom_prog_pkg::ADDR_W-1:0] o_addr,
  output logic o_init_n,
  output logic o_oe_n,
  output logic o_reg_clk,
  output logic o_vcc_prog,
  output logic o_vcc_vlow,
  output logic o_vcc_vhigh,
  output logic [prom_prog_pkg::DATA_W-1:0] o_out_prog,
  output logic o_busy,
  output logic o_done,
  output logic o_fail
);
  import prom_prog_pkg::*;

  prog_s s_reg;
  prog_s s_next;
  logic sensed;

  // second synchroniser stage only; the first is never read by logic
  // whole bus is synchronised first, so no mux sits in front of the first stage
  assign sensed = s_reg.sync_b[s_reg.bit_sel];

  always_comb
  begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.sync_a = i_prom_q;
    s_next.sync_b = s_reg.sync_a;
    if (s_reg.cool != '0)
    begin
      s_next.cool = s_reg.cool - 1'b1;
    end
    if (s_reg.timer != '0)
    begin
      s_next.timer = s_reg.timer - 1'b1;
    end
    case (s_reg.state)
      ST_IDLE:
      begin
        s_next.pins.oe_n = 1'b1;
        if (i_start)
        begin
          s_next.pins.addr = i_addr;
          s_next.pins.init_n = ~i_addr[ADDR_W-1];
          s_next.bit_sel = i_bit;
          s_next.tries = '0;
          s_next.extras = '0;
          s_next.verified = 1'b0;
          s_next.busy = 1'b1;
          s_next.fail = 1'b0;
          s_next.timer = CNT_W'(GAP_CYC);
          s_next.state = ST_SETUP;
        end
      end
      ST_SETUP:
      begin
        // wait out the cool-down so supply duty stays within limit
        if (s_reg.timer == '0 && s_reg.cool == '0)
        begin
          s_next.pins.vcc_vlow = 1'b0;
          s_next.pins.vcc_vhigh = 1'b0;
          s_next.pins.vcc_prog = 1'b1;
          s_next.pins.out_prog = '0;
          s_next.pins.out_prog[s_reg.bit_sel] = 1'b1;
          s_next.timer = CNT_W'(SETTLE_CYC);
          s_next.state = ST_RAISE;
        end
      end
      ST_RAISE:
      begin
        if (s_reg.timer == '0)
        begin
          s_next.pins.oe_n = 1'b0;
          s_next.timer = CNT_W'(PULSE_CYC - 1);
          s_next.state = ST_PULSE;
        end
      end
      ST_PULSE:
      begin
        if (s_reg.timer == '0)
        begin
          s_next.pins.oe_n = 1'b1;
          s_next.pins.out_prog = '0;
          // each burst costs roughly its own length times three of rest
          s_next.cool = (CNT_W+3)'((SETTLE_CYC + PULSE_CYC + 2 * GAP_CYC) * DUTY_MULT);
          s_next.timer = CNT_W'(GAP_CYC);
          if (s_reg.verified)
          begin
            s_next.extras = s_reg.extras + 1'b1;
          end
          else
          begin
            s_next.tries = s_reg.tries + 1'b1;
          end
          s_next.state = ST_DROP;
        end
      end
      ST_DROP:
      begin
        if (s_reg.timer == '0)
        begin
          s_next.pins.vcc_prog = 1'b0;
          if (s_reg.verified)
          begin
            s_next.state = (s_reg.extras == 3'(EXTRA_PULSES)) ? ST_DONE : ST_SETUP;
          end
          else
          begin
            s_next.pins.vcc_vlow = 1'b1;
            s_next.pins.oe_n = 1'b0;
            s_next.sample_ok = 1'b1;
            s_next.timer = CNT_W'(SETTLE_CYC);
            s_next.state = ST_VLOW;
          end
        end
      end
      ST_VLOW, ST_VHIGH:
      begin
        // clock high mid-wait, then sample after settling and sync delay
        s_next.pins.reg_clk = (s_reg.timer < CNT_W'(SETTLE_CYC / 2));
        if (s_reg.timer == '0)
        begin
          s_next.sample_ok = s_reg.sample_ok & sensed;
          s_next.pins.reg_clk = 1'b0;
          if (s_reg.state == ST_VLOW)
          begin
            s_next.pins.vcc_vlow = 1'b0;
            s_next.pins.vcc_vhigh = 1'b1;
            s_next.timer = CNT_W'(SETTLE_CYC);
            s_next.state = ST_VHIGH;
          end
          else
          begin
            s_next.state = ST_CHECK;
          end
        end
      end
      ST_CHECK:
      begin
        s_next.pins.oe_n = 1'b1;
        s_next.pins.vcc_vhigh = 1'b0;
        if (s_reg.sample_ok)
        begin
          s_next.verified = 1'b1;
          s_next.state = ST_SETUP;
        end
        else if (s_reg.tries == 4'(MAX_TRIES))
        begin
          s_next.state = ST_FAIL;
        end
        else
        begin
          s_next.state = ST_SETUP;
        end
      end
      ST_DONE:
      begin
        s_next.busy = 1'b0;
        // caller starts its full-array readback from this pulse
        s_next.done = 1'b1;
        s_next.state = ST_IDLE;
      end
      ST_FAIL:
      begin
        s_next.busy = 1'b0;
        s_next.done = 1'b1;
        s_next.fail = 1'b1;
        s_next.state = ST_IDLE;
      end
      default:
      begin
        s_next.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      s_reg <= '0;
      s_reg.state <= ST_IDLE;
      s_reg.pins.oe_n <= 1'b1;
      s_reg.pins.init_n <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign o_addr = s_reg.pins.addr;
  assign o_init_n = s_reg.pins.init_n;
  assign o_oe_n = s_reg.pins.oe_n;
  assign o_reg_clk = s_reg.pins.reg_clk;
  assign o_vcc_prog = s_reg.pins.vcc_prog;
  assign o_vcc_vlow = s_reg.pins.vcc_vlow;
  assign o_vcc_vhigh = s_reg.pins.vcc_vhigh;
  assign o_out_prog = s_reg.pins.out_prog;
  assign o_busy = s_reg.busy;
  assign o_done = s_reg.done;
  assign o_fail = s_reg.fail;
endmodule
`default_nettype wire

/* test/prom_fuse_model.sv */
// behavioural registered prom seen through its programming pins
`timescale 1ns/10ps
`default_nettype none
module prom_fuse_model
  import prom_prog_pkg::*;
(
  input wire logic [prom_prog_pkg::ADDR_W-1:0] i_addr,
  input wire logic i_init_n,
  input wire logic i_oe_n,
  input wire logic i_reg_clk,
  input wire logic i_vcc_prog,
  input wire logic [prom_prog_pkg::DATA_W-1:0] i_out_prog,
  input wire logic [3:0] i_need,
  output logic [prom_prog_pkg::DATA_W-1:0] o_q
);
  logic [DATA_W-1:0] fuse_reg [0:1024];
  logic [DATA_W-1:0] hits_reg [0:1024];
  logic [DATA_W-1:0] out_reg = '0;
  logic [10:0] word;
  assign word = i_init_n ? {1'b0, i_addr} : 11'h0400;
  initial
    for (int w = 0; w <= 1024; w++)
    begin
      fuse_reg[w] = '0;
      hits_reg[w] = '0;
    end
  // a fuse opens only after i_need pulses, so a slow part forces retries
  always @(negedge i_oe_n)
    // the raised output is stable long before any enable edge, unlike the supply flag
    if (i_vcc_prog && i_out_prog != '0)
    begin
      hits_reg[word] = hits_reg[word] + 8'h01;
      if (hits_reg[word] >= 8'(i_need))
        fuse_reg[word] = fuse_reg[word] | i_out_prog;
    end
  always @(posedge i_reg_clk)
    out_reg <= fuse_reg[word];
  // a disabled part shows the inverse, so a read without enable cannot pass
  assign o_q = i_oe_n ? ~out_reg : out_reg;
endmodule
`default_nettype wire

/* test/prom_prog_assertions.sv */
// concurrent checks on the prom fuse programmer pins
`timescale 1ns/10ps
`default_nettype none
module prom_prog_chk
  import prom_prog_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [prom_prog_pkg::ADDR_W-1:0] o_addr,
  input wire logic o_init_n,
  input wire logic o_oe_n,
  input wire logic o_reg_clk,
  input wire logic o_vcc_prog,
  input wire logic o_vcc_vlow,
  input wire logic o_vcc_vhigh,
  input wire logic [prom_prog_pkg::DATA_W-1:0] o_out_prog,
  input wire logic o_done,
  input wire logic o_fail
);
  logic [CNT_W-1:0] low_cnt;
  logic [CNT_W-1:0] hi_run;
  logic [CNT_W+2:0] lo_run;
  logic [3:0] v_cnt;
  logic [3:0] x_cnt;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // lo_run starts saturated so the first burst after reset owes no cool-down
  always_ff @(posedge i_clk or posedge i_rst)
    if (i_rst)
    begin
      low_cnt <= '0;
      hi_run <= '0;
      lo_run <= '1;
      v_cnt <= '0;
      x_cnt <= '0;
    end
    else
    begin
      low_cnt <= o_oe_n ? '0 : low_cnt + 1'b1;
      hi_run <= $rose(o_vcc_prog) ? CNT_W'(1) : hi_run + CNT_W'(o_vcc_prog);
      lo_run <= o_vcc_prog ? '0 : lo_run + (CNT_W+3)'(~&lo_run);
      v_cnt <= o_done ? '0 : v_cnt + 4'($rose(o_vcc_vlow));
      x_cnt <= $rose(o_vcc_vlow) ? '0 : x_cnt + 4'($fell(o_oe_n) && o_vcc_prog);
    end
  chk_pulse_width: assert property ($rose(o_oe_n) && o_vcc_prog |-> low_cnt == PULSE_CYC)
    else $error("programming pulse width wrong");
  chk_clk_enabled: assert property ($rose(o_reg_clk) |-> !o_oe_n && !o_vcc_prog && o_out_prog == '0
    && (o_vcc_vlow || o_vcc_vhigh))
    else $error("verify clock outside an enabled read");
  chk_one_level: assert property ($onehot0({o_vcc_prog, o_vcc_vlow, o_vcc_vhigh}))
    else $error("more than one supply level selected");
  chk_tries_bound: assert property (o_done |-> v_cnt <= MAX_TRIES && (!o_fail || v_cnt == MAX_TRIES))
    else $error("attempt count wrong at done");
  chk_init_follow: assert property (o_init_n == !o_addr[9])
    else $error("init pin does not follow upper address bit");
  chk_extra_pulses: assert property (o_done && !o_fail |-> x_cnt == EXTRA_PULSES)
    else $error("extra pulse count wrong");
  chk_duty_limit: assert property ($rose(o_vcc_prog) |-> lo_run >= DUTY_MULT * hi_run)
    else $error("supply duty too high");
  chk_one_output: assert property (o_out_prog != '0 |-> $onehot(o_out_prog) && o_vcc_prog)
    else $error("output raised wrongly");
  chk_disabled_rise: assert property ($rose(o_vcc_prog) |-> o_oe_n && $stable(o_addr))
    else $error("supply raised while enabled");
  cover property (o_done && !o_fail);
  cover property ($rose(o_reg_clk));
  cover property ($rose(o_vcc_prog) && !o_init_n);
endmodule
bind prom_fuse_programmer prom_prog_chk chk (.i_clk, .i_rst, .o_addr, .o_init_n, .o_oe_n, .o_reg_clk,
  .o_vcc_prog, .o_vcc_vlow, .o_vcc_vhigh, .o_out_prog, .o_done, .o_fail);
`default_nettype wire

/* test/tb.sv */
// self-checking bench for the prom fuse programmer
`timescale 1ns/10ps
`default_nettype none
module tb;
  import prom_prog_pkg::*;
  typedef struct packed {logic [ADDR_W-1:0] addr; logic [BIT_W-1:0] bsel; logic [3:0] need;} row_s;
  row_s rows [0:1];
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_start = 1'b0;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [BIT_W-1:0] i_bit = '0;
  logic [3:0] need = 4'h1;
  logic [DATA_W-1:0] prom_q;
  logic [ADDR_W-1:0] o_addr;
  logic [DATA_W-1:0] o_out_prog;
  logic o_init_n, o_oe_n, o_reg_clk, o_vcc_prog, o_vcc_vlow, o_vcc_vhigh, o_busy, o_done, o_fail;
  int num_errors = 0;
  int check_count = 0;
  prom_fuse_programmer dut (.i_clk, .i_rst, .i_start, .i_addr, .i_bit, .i_prom_q(prom_q), .o_addr, .o_init_n,
    .o_oe_n, .o_reg_clk, .o_vcc_prog, .o_vcc_vlow, .o_vcc_vhigh, .o_out_prog, .o_busy, .o_done, .o_fail);
  prom_fuse_model mdl (.i_addr(o_addr), .i_init_n(o_init_n), .i_oe_n(o_oe_n), .i_reg_clk(o_reg_clk),
    .i_vcc_prog(o_vcc_prog), .i_out_prog(o_out_prog), .i_need(need), .o_q(prom_q));
  always #4 i_clk = ~i_clk;
  task automatic chk_word(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp, input string what);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (98000) @(posedge i_clk);
    num_errors++;
    summarize();
  end
  initial
  begin
    rows[0] = '{10'h0200, 3'h3, 4'h1};
    rows[1] = '{10'h0005, 3'h0, 4'h2};
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    @(negedge i_clk);
    chk_word({7'h00, o_oe_n}, 8'h01, "oe_n");
    foreach (rows[k])
    begin
      int w;
      w = rows[k].addr[9] ? 1024 : int'(rows[k].addr);
      @(posedge i_clk);
      i_addr <= rows[k].addr;
      i_bit <= rows[k].bsel;
      need <= rows[k].need;
      i_start <= 1'b1;
      @(posedge i_clk);
      i_start <= 1'b0;
      for (int n = 0; n < 70000 && o_done !== 1'b1; n++)
        @(negedge i_clk);
      chk_word({6'h00, o_done, o_fail}, 8'h02, "done_fail");
      chk_word(mdl.fuse_reg[w], 8'h01 << rows[k].bsel, "fuse");
      chk_word(mdl.hits_reg[w], 8'(rows[k].need) + 8'(EXTRA_PULSES), "pulses");
    end
    for (int w = 0; w <= 1024; w++)
    begin
      logic [DATA_W-1:0] want;
      want = '0;
      foreach (rows[k])
        if (w == (rows[k].addr[9] ? 1024 : int'(rows[k].addr)))
          want = want | (8'h01 << rows[k].bsel);
      chk_word(mdl.fuse_reg[w], want, "readback");
    end
    @(posedge i_clk);
    i_addr <= 10'h0007;
    i_bit <= 3'h0;
    i_start <= 1'b1;
    @(posedge i_clk);
    i_start <= 1'b0;
    repeat (8) @(posedge i_clk);
    @(negedge i_clk);
    chk_word(o_addr[7:0], 8'h07, "addr_held");
    chk_word({5'h00, o_oe_n, o_vcc_prog, o_busy}, 8'h05, "pins_before_rise");
    @(posedge i_clk);
    i_rst <= 1'b1;
    @(negedge i_clk);
    chk_word(o_out_prog, 8'h00, "reset_out_prog");
    chk_word({6'h00, o_oe_n, o_busy}, 8'h02, "reset_oe_busy");
    @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
    summarize();
  end
endmodule
`default_nettype wire
